// File: lbicf_cfg.svh
// offsets, field positions, reset values and timing counts of the bypass switch controller
`ifndef LBICF_CFG_SVH
`define LBICF_CFG_SVH

// **********************************************************************
// slave addresses and broadcast bytes
// **********************************************************************
`define LBICF_SC_PREFIX 3'h5
`define LBICF_AC_PREFIX 3'h2
`define LBICF_BC_WR     8'h18
`define LBICF_BC_RD     8'h19

// **********************************************************************
// channel_config layout (14 bits)
// **********************************************************************
`define LBICF_CFG_OTH_HI 13
`define LBICF_CFG_OTH_LO 12
`define LBICF_CFG_STH_HI 11
`define LBICF_CFG_STH_LO 10
`define LBICF_CFG_MC_HI  9
`define LBICF_CFG_MC_LO  8
`define LBICF_CFG_DV_HI  7

// **********************************************************************
// write data byte layout
// **********************************************************************
`define LBICF_WB_FMT     7
`define LBICF_WB_CH_HI   6
`define LBICF_WB_CH_LO   4
`define LBICF_WB_CODE_HI 3
`define LBICF_WB_CODE_LO 2

// **********************************************************************
// reset values
// **********************************************************************
`define LBICF_OTH_RST_BASE 2'h3
`define LBICF_OTH_RST_ALT  2'h1
`define LBICF_STH_RST      2'h0
`define LBICF_MC_RST_BASE  2'h0
`define LBICF_MC_RST_ALT   2'h1
`define LBICF_DV_RST       8'h00
`define LBICF_CH_PTR_RST   3'h0
`define LBICF_CFG_RST_BASE {`LBICF_OTH_RST_BASE, `LBICF_STH_RST, `LBICF_MC_RST_BASE, `LBICF_DV_RST}
`define LBICF_CFG_RST_ALT  {`LBICF_OTH_RST_ALT, `LBICF_STH_RST, `LBICF_MC_RST_ALT, `LBICF_DV_RST}

// **********************************************************************
// thresholds and timing
// **********************************************************************
`define LBICF_OTH_STEP_DV        8'h2d
`define LBICF_OPEN_PERSIST_NS    15000
`define LBICF_CLK_PERIOD_NS      8
`define LBICF_OPEN_PERSIST_CYC   ((`LBICF_OPEN_PERSIST_NS + `LBICF_CLK_PERIOD_NS - 1) / `LBICF_CLK_PERIOD_NS)

`endif

// File: lbicf_pkg.sv
// types shared by the bypass switch controller
package lbicf_pkg;

  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_ADDR    = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_WR      = 7'h08,
    ST_WR_ACK  = 7'h10,
    ST_RD      = 7'h20,
    ST_RD_ACK  = 7'h40
  } lbicf_state_t;

  typedef enum logic [1:0] {
    KIND_SC = 2'h0,
    KIND_AC = 2'h1,
    KIND_BC = 2'h2
  } lbicf_kind_t;

  typedef enum logic [1:0] {
    MODE_SW_OFF = 2'h0,
    MODE_SW_ON  = 2'h1,
    MODE_PWM    = 2'h2,
    MODE_FADE   = 2'h3
  } lbicf_mode_t;

endpackage : lbicf_pkg

// File: lbicf_sync.sv
// two flip-flop synchroniser
`timescale 1ns/1ns
module lbicf_sync #(
  parameter int P_W = 1
)(
  input  wire logic           i_clock,
  input  wire logic [P_W-1:0] i_d,
  output logic      [P_W-1:0] o_q
);
  logic [P_W-1:0] meta_r;

  always_ff @(posedge i_clock) begin
    meta_r <= i_d;
    o_q    <= meta_r;
  end
endmodule : lbicf_sync

// File: lbicf_open_det.sv
// open-LED fault detector for one channel
`timescale 1ns/1ns
module lbicf_open_det #(
  parameter int P_CYC = 1875
)(
  input  wire logic i_clock,
  input  wire logic i_nrst,
  input  wire logic i_over_abs,
  input  wire logic i_over_thr,
  output logic      o_event,
  output logic      o_present
);
  logic [15:0] cnt_r;
  logic        hit;

  assign hit = i_over_abs | (i_over_thr && (cnt_r == 16'(P_CYC))); // [R14]

  // persistence timer, saturates at the limit
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      cnt_r <= 16'h0000;
    end else if (!i_over_thr) begin
      cnt_r <= 16'h0000;
    end else if (cnt_r != 16'(P_CYC)) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_present <= 1'b0;
      o_event   <= 1'b0;
    end else begin
      o_present <= hit;
      o_event   <= hit & ~o_present;
    end
  end
endmodule : lbicf_open_det

// File: lbicf_top.sv
// serial command, readback, alert query and open-fault logic of the bypass switch controller
// Notes on behaviour
// R1 - open threshold code maps to 4.5V times (code plus one)
// R2 - reset open threshold code: 18V base variant, 9V alternate variant
// R3 - short write changes that channel's open threshold bits 13:12, then its mode bits 9:8 at STOP
// R4 - long write changes short threshold bits 11:10; led count is code plus one
// R5 - channel read returns flags plus six config bits, then dim value
// R6 - last written channel index is kept for reads; starts at zero
// R7 - single-channel address is 101 followed by the four id pins
// R8 - broadcast write 00011000 restarts all dimming counters, no register change
// R9 - broadcast read reply is 010, id pins, then a one
// R10 - broadcast read address not acknowledged unless alert is asserted
// R11 - alert query at 0001100 read: acknowledge and send address plus one
// R12 - during reply, reading 0 while sending 1 aborts the transfer
// R13 - completed reply releases alert until a new fault event; flags kept
// R14 - open fault at once above 22V, or above threshold beyond 15us
// R15 - open fault sets flag, asserts alert, forces bypass switch on
// R16 - forced switch returns to normal only after a rewrite of its channel
// R17 - write byte: bit7 format, bits 6:4 channel, bits 3:0 codes
// R18 - data staged until STOP; thresholds update once their byte is acknowledged
// R19 - all-channel address is 010 followed by the four id pins
// R20 - comparator outputs are synchronised before persistence timing
`timescale 1ns/1ns
`include "lbicf_cfg.svh"
module lbicf_top
  import lbicf_pkg::*;
#(
  parameter bit P_ALT_VARIANT = 1'b0,
  parameter int P_PERSIST_CYC = `LBICF_OPEN_PERSIST_CYC
)(
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  input  wire logic        i_dim_clock,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe,
  input  wire logic [3:0]  i_slave_id,
  input  wire logic [7:0]  i_open_abs,
  input  wire logic [7:0]  i_open_thr,
  input  wire logic [7:0]  i_short_cmp,
  output logic             o_alert_n,
  output logic [7:0]       o_bypass_on,
  output logic [63:0]      o_open_trip_dv,
  output logic [23:0]      o_series_led_count
);
  localparam logic [13:0] CFG_RST = P_ALT_VARIANT ? `LBICF_CFG_RST_ALT : `LBICF_CFG_RST_BASE;

  // **********************************************************************
  // pin synchronisation
  // **********************************************************************
  logic        scl_s, sda_s, scl_d_r, sda_d_r;
  logic [3:0]  id_s;
  logic [7:0]  abs_s, thr_s, short_s, short_d_r;
  logic [29:0] pin_s;

  lbicf_sync #(.P_W(30)) u_pin_sync (
    .i_clock (i_clock),
    .i_d     ({i_scl, i_sda, i_slave_id, i_open_abs, i_open_thr, i_short_cmp}), // [R20]
    .o_q     (pin_s)
  );
  assign {scl_s, sda_s, id_s, abs_s, thr_s, short_s} = pin_s;

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      scl_d_r   <= 1'b1;
      sda_d_r   <= 1'b1;
      short_d_r <= 8'h00;
    end else begin
      scl_d_r   <= scl_s;
      sda_d_r   <= sda_s;
      short_d_r <= short_s;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // **********************************************************************
  // registers and status
  // **********************************************************************
  logic [13:0] cfg_r [8];
  logic [2:0]  ch_ptr_r;
  logic [7:0]  olf_r, slf_r, forced_r, open_ev, open_pres;
  logic        quiet_r, alert_on;
  logic        pend_r, pend_long_r;
  logic [2:0]  pend_ch_r;
  logic [1:0]  pend_mc_r;
  logic [7:0]  pend_dv_r;

  assign alert_on = ((|olf_r) | (|slf_r)) & ~quiet_r;

  // **********************************************************************
  // serial engine
  // **********************************************************************
  lbicf_state_t state_r;
  lbicf_kind_t  kind_r;
  logic         rw_r, nack_r, ara_r, sync_tog_r;
  logic [3:0]   bitcnt_r;
  logic [7:0]   sr_r, tx_r, rd_byte;
  logic [1:0]   byte_idx_r;
  logic         sc_hit, ac_hit, bcw_hit, bcr_hit, addr_hit, byte_done, ara_done;

  assign sc_hit   = sr_r[7:1] == {`LBICF_SC_PREFIX, id_s};            // [R7]
  assign ac_hit   = sr_r[7:1] == {`LBICF_AC_PREFIX, id_s};            // [R19]
  assign bcw_hit  = sr_r == `LBICF_BC_WR;
  assign bcr_hit  = (sr_r == `LBICF_BC_RD) && alert_on;               // [R10] [R11]
  assign addr_hit = sc_hit | ac_hit | bcw_hit | bcr_hit;
  assign byte_done = (state_r == ST_WR) && scl_fall && (bitcnt_r == 4'h8);
  assign ara_done  = (state_r == ST_RD) && scl_fall && (bitcnt_r == 4'h8) && ara_r;

  // next byte to send
  always_comb begin
    rd_byte = 8'hff;
    if (kind_r == KIND_BC) begin
      rd_byte = {`LBICF_AC_PREFIX, id_s, 1'b1};                       // [R9]
    end else if (kind_r == KIND_SC) begin
      if (byte_idx_r == 2'h0) begin
        rd_byte = {olf_r[ch_ptr_r], slf_r[ch_ptr_r],
                   cfg_r[ch_ptr_r][`LBICF_CFG_OTH_HI:`LBICF_CFG_MC_LO]}; // [R5] [R6]
      end else if (byte_idx_r == 2'h1) begin
        rd_byte = cfg_r[ch_ptr_r][`LBICF_CFG_DV_HI:0];                 // [R5]
      end
    end else begin
      if (byte_idx_r == 2'h0) begin
        rd_byte = 8'h00;
      end else if (byte_idx_r == 2'h1) begin
        rd_byte = olf_r;
      end else if (byte_idx_r == 2'h2) begin
        rd_byte = slf_r;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      state_r    <= ST_IDLE;
      kind_r     <= KIND_SC;
      rw_r       <= 1'b0;
      ara_r      <= 1'b0;
      nack_r     <= 1'b1;
      bitcnt_r   <= 4'h0;
      sr_r       <= 8'h00;
      tx_r       <= 8'hff;
      byte_idx_r <= 2'h0;
      o_sda_oe   <= 1'b0;
    end else if (bus_start) begin
      state_r    <= ST_ADDR;
      bitcnt_r   <= 4'h0;
      byte_idx_r <= 2'h0;
      ara_r      <= 1'b0;
      o_sda_oe   <= 1'b0;
    end else if (bus_stop) begin
      state_r  <= ST_IDLE;
      o_sda_oe <= 1'b0;
    end else begin
      case (state_r)
        ST_ADDR, ST_WR: begin
          if (scl_rise && bitcnt_r != 4'h8) begin
            sr_r     <= {sr_r[6:0], sda_s};
            bitcnt_r <= bitcnt_r + 4'h1;
          end else if (scl_fall && bitcnt_r == 4'h8) begin
            if (state_r == ST_WR || addr_hit) begin
              state_r  <= (state_r == ST_WR) ? ST_WR_ACK : ST_ADDR_ACK;
              o_sda_oe <= 1'b1;
            end else begin
              state_r <= ST_IDLE;
            end
            if (state_r == ST_ADDR) begin
              rw_r   <= sr_r[0];
              ara_r  <= bcr_hit;
              kind_r <= sc_hit ? KIND_SC : (ac_hit ? KIND_AC : KIND_BC);
            end
          end
        end
        ST_ADDR_ACK, ST_WR_ACK: begin
          if (scl_fall) begin
            bitcnt_r <= 4'h0;
            if (state_r == ST_WR_ACK) begin
              byte_idx_r <= byte_idx_r + 2'h1;
            end
            if (rw_r && state_r == ST_ADDR_ACK) begin
              state_r  <= ST_RD;
              tx_r     <= rd_byte;
              o_sda_oe <= ~rd_byte[7];
            end else begin
              state_r  <= ST_WR;
              o_sda_oe <= 1'b0;
            end
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            bitcnt_r <= bitcnt_r + 4'h1;
            if (ara_r && tx_r[7] && !sda_s) begin
              state_r  <= ST_IDLE;                                    // [R12]
              o_sda_oe <= 1'b0;
            end
          end else if (scl_fall) begin
            if (bitcnt_r == 4'h8) begin
              state_r    <= ST_RD_ACK;
              o_sda_oe   <= 1'b0;
              byte_idx_r <= byte_idx_r + 2'h1;
            end else begin
              tx_r     <= {tx_r[6:0], 1'b1};
              o_sda_oe <= ~tx_r[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            nack_r <= sda_s;
          end else if (scl_fall) begin
            bitcnt_r <= 4'h0;
            if (nack_r) begin
              state_r <= ST_IDLE;
            end else begin
              state_r  <= ST_RD;
              ara_r    <= 1'b0;
              tx_r     <= rd_byte;
              o_sda_oe <= ~rd_byte[7];
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign o_sda = 1'b0;

  // **********************************************************************
  // command decode, staging and commit
  // **********************************************************************
  logic       commit;
  logic [7:0] clr_mask;

  assign commit   = bus_stop && pend_r;                               // [R18]
  assign clr_mask = commit ? (8'h01 << pend_ch_r) : 8'h00;

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      for (int i = 0; i < 8; i++) begin
        cfg_r[i] <= CFG_RST;                                          // [R2] [R4]
      end
      ch_ptr_r    <= `LBICF_CH_PTR_RST;                               // [R6]
      pend_r      <= 1'b0;
      pend_long_r <= 1'b0;
      pend_ch_r   <= 3'h0;
      pend_mc_r   <= 2'h0;
      pend_dv_r   <= 8'h00;
    end else begin
      if (byte_done && kind_r == KIND_SC && byte_idx_r == 2'h0) begin
        ch_ptr_r    <= sr_r[`LBICF_WB_CH_HI:`LBICF_WB_CH_LO];         // [R6] [R17]
        pend_r      <= 1'b1;
        pend_long_r <= sr_r[`LBICF_WB_FMT];
        pend_ch_r   <= sr_r[`LBICF_WB_CH_HI:`LBICF_WB_CH_LO];
        pend_mc_r   <= sr_r[1:0];
        pend_dv_r   <= cfg_r[sr_r[`LBICF_WB_CH_HI:`LBICF_WB_CH_LO]][`LBICF_CFG_DV_HI:0];
        if (sr_r[`LBICF_WB_FMT]) begin
          cfg_r[sr_r[`LBICF_WB_CH_HI:`LBICF_WB_CH_LO]][`LBICF_CFG_STH_HI:`LBICF_CFG_STH_LO]
            <= sr_r[`LBICF_WB_CODE_HI:`LBICF_WB_CODE_LO];             // [R4] [R18]
        end else begin
          cfg_r[sr_r[`LBICF_WB_CH_HI:`LBICF_WB_CH_LO]][`LBICF_CFG_OTH_HI:`LBICF_CFG_OTH_LO]
            <= sr_r[`LBICF_WB_CODE_HI:`LBICF_WB_CODE_LO];             // [R3] [R18]
        end
      end else if (byte_done && kind_r == KIND_SC && byte_idx_r == 2'h1 && pend_long_r) begin
        pend_dv_r <= sr_r;
      end else if (commit) begin
        pend_r <= 1'b0;
        cfg_r[pend_ch_r][`LBICF_CFG_MC_HI:0] <= {pend_mc_r, pend_dv_r};
      end
    end
  end

  // **********************************************************************
  // open-fault detection, flags and alert
  // **********************************************************************
  for (genvar g = 0; g < 8; g++) begin : g_det
    lbicf_open_det #(.P_CYC(P_PERSIST_CYC)) u_det (
      .i_clock    (i_clock),
      .i_nrst     (i_nrst),
      .i_over_abs (abs_s[g]),
      .i_over_thr (thr_s[g]),
      .o_event    (open_ev[g]),
      .o_present  (open_pres[g])
    );
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      olf_r    <= 8'h00;
      slf_r    <= 8'h00;
      forced_r <= 8'h00;
      quiet_r  <= 1'b0;
    end else begin
      olf_r    <= (olf_r & ~(clr_mask & ~open_pres)) | open_ev;       // [R15]
      slf_r    <= (slf_r & ~(clr_mask & ~short_s)) | short_s;
      forced_r <= (forced_r & ~clr_mask) | open_ev;                   // [R15] [R16]
      if ((|open_ev) || (|(short_s & ~short_d_r))) begin
        quiet_r <= 1'b0;
      end else if (ara_done) begin
        quiet_r <= 1'b1;                                              // [R13]
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_alert_n <= 1'b1;
    end else begin
      o_alert_n <= ~alert_on;                                         // [R15]
    end
  end

  // **********************************************************************
  // dimming counter on the dimming clock
  // **********************************************************************
  logic       dim_nrst, tog_s, tog_d_r;
  logic [7:0] dim_bin_r, dim_gray_r, dim_bin_nxt, gray_s, dim_cnt;

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      sync_tog_r <= 1'b0;
    end else if ((state_r == ST_ADDR) && scl_fall && (bitcnt_r == 4'h8) && bcw_hit) begin
      sync_tog_r <= ~sync_tog_r;                                      // [R8]
    end
  end

  lbicf_sync #(.P_W(1)) u_dim_rst_sync (
    .i_clock (i_dim_clock),
    .i_d     (i_nrst),
    .o_q     (dim_nrst)
  );

  lbicf_sync #(.P_W(1)) u_tog_sync (
    .i_clock (i_dim_clock),
    .i_d     (sync_tog_r),
    .o_q     (tog_s)
  );

  assign dim_bin_nxt = (tog_s ^ tog_d_r) ? 8'h00 : dim_bin_r + 8'h01; // [R8]

  always_ff @(posedge i_dim_clock) begin
    if (!dim_nrst) begin
      tog_d_r    <= 1'b0;
      dim_bin_r  <= 8'h00;
      dim_gray_r <= 8'h00;
    end else begin
      tog_d_r    <= tog_s;
      dim_bin_r  <= dim_bin_nxt;
      dim_gray_r <= dim_bin_nxt ^ (dim_bin_nxt >> 1);
    end
  end

  lbicf_sync #(.P_W(8)) u_gray_sync (
    .i_clock (i_clock),
    .i_d     (dim_gray_r),
    .o_q     (gray_s)
  );

  always_comb begin
    dim_cnt[7] = gray_s[7];
    for (int i = 6; i >= 0; i--) begin
      dim_cnt[i] = dim_cnt[i+1] ^ gray_s[i];
    end
  end

  // **********************************************************************
  // switch drive and threshold levels
  // **********************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_bypass_on        <= 8'h00;
      o_open_trip_dv     <= 64'h0;
      o_series_led_count <= 24'h0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        case (lbicf_mode_t'(cfg_r[i][`LBICF_CFG_MC_HI:`LBICF_CFG_MC_LO]))
          MODE_SW_OFF: o_bypass_on[i] <= forced_r[i];                 // [R15]
          MODE_SW_ON:  o_bypass_on[i] <= 1'b1;
          default:     o_bypass_on[i] <= forced_r[i] | (dim_cnt >= cfg_r[i][7:0]);
        endcase
        o_open_trip_dv[8*i +: 8] <= `LBICF_OTH_STEP_DV *
          ({6'h00, cfg_r[i][`LBICF_CFG_OTH_HI:`LBICF_CFG_OTH_LO]} + 8'h01); // [R1]
        o_series_led_count[3*i +: 3] <=
          {1'b0, cfg_r[i][`LBICF_CFG_STH_HI:`LBICF_CFG_STH_LO]} + 3'h1;    // [R4]
      end
    end
  end
endmodule : lbicf_top

// File: lbicf_assertions.sv
// port assertions of the bypass switch controller
`timescale 1ns/1ns
module lbicf_assertions #(
  parameter int P_PERSIST_CYC = 1875
)(
  input wire logic        i_clock,
  input wire logic        i_nrst,
  input wire logic        i_dim_clock,
  input wire logic        i_scl,
  input wire logic        i_sda,
  input wire logic [7:0]  i_open_abs,
  input wire logic [7:0]  i_open_thr,
  input wire logic        o_sda,
  input wire logic        o_sda_oe,
  input wire logic        o_alert_n,
  input wire logic [7:0]  o_bypass_on,
  input wire logic [63:0] o_open_trip_dv,
  input wire logic [23:0] o_series_led_count
);
  logic [7:0] thr_prev_r;
  logic [15:0] thr_cnt_r;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  // **********************************************************************
  // steady threshold run length
  // **********************************************************************
  always_ff @(posedge i_clock) begin
    thr_prev_r <= i_open_thr;
  end
  always_ff @(posedge i_clock) begin
    if (!i_nrst || i_open_thr == 8'h00 || i_open_thr != thr_prev_r) begin
      thr_cnt_r <= 16'h0000;
    end else if (thr_cnt_r != 16'hffff) begin
      thr_cnt_r <= thr_cnt_r + 16'h0001;
    end
  end
  function automatic bit levels_ok(logic [63:0] v);
    levels_ok = 1'b1;
    for (int k = 0; k < 8; k++) begin
      if (!(v[k*8 +: 8] inside {8'h2d, 8'h5a, 8'h87, 8'hb4})) levels_ok = 1'b0;
    end
  endfunction : levels_ok
  function automatic bit counts_ok(logic [23:0] v);
    counts_ok = 1'b1;
    for (int k = 0; k < 8; k++) begin
      if (!(v[k*3 +: 3] inside {3'h1, 3'h2, 3'h3, 3'h4})) counts_ok = 1'b0;
    end
  endfunction : counts_ok
  AST_SDA_LEVEL: assert property (o_sda == 1'b0)
    else $error("sda data level not low");
  AST_OE_SCL_LOW: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("sda drive changed while bus clock high");
  AST_RESET_STATE: assert property ($rose(i_nrst) |=> o_alert_n && !o_sda_oe
    && o_bypass_on == 8'h00 && o_open_trip_dv == {8{8'hb4}} && o_series_led_count == {8{3'h1}})
    else $error("wrong state after reset");
  AST_ABS_ALERT: assert property ($rose(|i_open_abs) |-> ##[1:8] !o_alert_n)
    else $error("alert missing after overvoltage");
  AST_ABS_FORCE: assert property (((i_open_abs & $past(i_open_abs, 8)) & ~o_bypass_on) == 8'h00)
    else $error("switch not forced on");
  AST_PERSIST_TRIP: assert property (thr_cnt_r == P_PERSIST_CYC + 8 |-> !o_alert_n
    && (i_open_thr & ~o_bypass_on) == 8'h00)
    else $error("persistent threshold not tripped");
  AST_BYPASS_OFF_IDLE: assert property (($past(o_bypass_on) & ~o_bypass_on) != 8'h00
    |-> i_scl && i_sda)
    else $error("switch released outside stop");
  AST_TRIP_LEVELS: assert property ($past(i_nrst) |-> levels_ok(o_open_trip_dv))
    else $error("illegal trip level");
  AST_LED_COUNTS: assert property ($past(i_nrst) |-> counts_ok(o_series_led_count))
    else $error("illegal led count");
  COV_ALERT_LOW: cover property ($fell(o_alert_n));
  COV_ALERT_FREE: cover property ($rose(o_alert_n));
  COV_SWITCH_OFF: cover property ($fell(|o_bypass_on));
endmodule : lbicf_assertions

// File: lbicf_i2c_host.sv
// serial bus master model
`timescale 1ns/1ns
module lbicf_i2c_host (
  input  wire logic i_clock,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask : tick
  task automatic start();
    tick(5);
    o_sda_low <= 1'b1;
    tick(5);
    o_scl <= 1'b0;
    tick(5);
  endtask : start
  task automatic stop();
    o_sda_low <= 1'b1;
    tick(5);
    o_scl <= 1'b1;
    tick(5);
    o_sda_low <= 1'b0;
    tick(10);
  endtask : stop
  // released line floats to the pull-up
  task automatic bit_io(input logic b, output logic r);
    o_sda_low <= !b;
    tick(5);
    o_scl <= 1'b1;
    tick(3);
    r = i_sda;
    tick(2);
    o_scl <= 1'b0;
    tick(5);
  endtask : bit_io
  task automatic xfer(input logic [7:0] w, input logic ai, output logic [7:0] r,
                      output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(w[i], r[i]);
    end
    bit_io(ai, a);
    ack = !a;
  endtask : xfer
endmodule : lbicf_i2c_host

// File: led_bypass_i2c_command_fault_tb.sv
// self-checking bench of the bypass switch controller
`timescale 1ns/1ns
module led_bypass_i2c_command_fault_tb;
  localparam int P_CYC = 20;
  logic        clk, nrst, dim_clk, scl, host_low, sda_oe, sda_o, alert_n;
  logic [3:0]  id;
  logic [7:0]  abs_v, thr_v, bypass;
  logic [63:0] trip_dv;
  logic [23:0] led_cnt;
  logic [7:0]  exp_q[$];
  wire         sda_w = !(host_low || (sda_oe && !sda_o));
  int          fail_count = 0, n_compared = 0, cyc = 0, ptr = 0;
  int          oth[8] = '{default: 3}, sth[8], mc[8], dv[8], oflag[8];
  lbicf_top #(.P_ALT_VARIANT(1'b0), .P_PERSIST_CYC(P_CYC)) i_lbicf_top (
    .i_clock(clk), .i_nrst(nrst), .i_dim_clock(dim_clk), .i_scl(scl), .i_sda(sda_w),
    .o_sda(sda_o), .o_sda_oe(sda_oe), .i_slave_id(id), .i_open_abs(abs_v),
    .i_open_thr(thr_v), .i_short_cmp(8'h00), .o_alert_n(alert_n), .o_bypass_on(bypass),
    .o_open_trip_dv(trip_dv), .o_series_led_count(led_cnt));
  lbicf_i2c_host i_lbicf_i2c_host (.i_clock(clk), .i_sda(sda_w), .o_scl(scl),
    .o_sda_low(host_low));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    dim_clk = 1'b0;
    #1;
    forever #3 dim_clk = ~dim_clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      test_done();
    end
  end
  // **********************************************************************
  // compare, bus and model tasks
  // **********************************************************************
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  task automatic test_done();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic xb(input logic [7:0] w, input logic ai, output logic [7:0] r, output logic a);
    i_lbicf_i2c_host.xfer(w, ai, r, a);
  endtask : xb
  task automatic check_fields();
    logic [63:0] t;
    logic [23:0] c;
    logic [7:0]  b;
    for (int k = 0; k < 8; k++) begin
      t[k*8 +: 8] = 8'(8'h2d * (oth[k] + 1));
      c[k*3 +: 3] = 3'(sth[k] + 1);
      b[k] = (oflag[k] != 0) || (mc[k] == 1) || (mc[k] > 1 && dv[k] == 0);
    end
    check(trip_dv, t);
    check(led_cnt, c);
    check(bypass, b);
  endtask : check_fields
  task automatic sc_write(input int fmt, input int ch, input int code, input int mode,
                          input int dim);
    logic [7:0] r;
    logic       a;
    i_lbicf_i2c_host.start();
    xb({3'h5, id, 1'b0}, 1'b1, r, a);
    check(a, 1'b1);
    xb({fmt[0], ch[2:0], code[1:0], mode[1:0]}, 1'b1, r, a);
    if (fmt != 0) begin
      sth[ch] = code;
      dv[ch] = dim;
    end else begin
      oth[ch] = code;
    end
    check_fields();
    if (fmt != 0) begin
      xb(dim[7:0], 1'b1, r, a);
    end
    i_lbicf_i2c_host.stop();
    mc[ch] = mode;
    ptr = ch;
    oflag[ch] = 0;
    check_fields();
  endtask : sc_write
  task automatic sc_read();
    logic [7:0] r;
    logic       a;
    exp_q.push_back({oflag[ptr][0], 1'b0, oth[ptr][1:0], sth[ptr][1:0], mc[ptr][1:0]});
    exp_q.push_back(dv[ptr][7:0]);
    i_lbicf_i2c_host.start();
    xb({3'h5, id, 1'b1}, 1'b1, r, a);
    check(a, 1'b1);
    xb(8'hff, 1'b0, r, a);
    check(r, exp_q.pop_front());
    xb(8'hff, 1'b1, r, a);
    check(r, exp_q.pop_front());
    i_lbicf_i2c_host.stop();
  endtask : sc_read
  task automatic probe(input logic [7:0] w, input logic ack, input logic [7:0] rw,
                       input logic [7:0] exp);
    logic [7:0] r;
    logic       a;
    i_lbicf_i2c_host.start();
    xb(w, 1'b1, r, a);
    check(a, ack);
    if (w[0] && a) begin
      xb(rw, 1'b1, r, a);
      check(r, exp);
    end
    i_lbicf_i2c_host.stop();
  endtask : probe
  // **********************************************************************
  // main sequence
  // **********************************************************************
  initial begin
    int f;
    int g;
    nrst = 1'b0;
    abs_v = 8'h00;
    thr_v = 8'h00;
    void'($urandom(52));
    id <= 4'($urandom());
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
    check(alert_n, 1'b1);
    check_fields();
    sc_read();
    for (int k = 0; k < 8; k++) begin
      sc_write(k / 4, $urandom_range(7), k % 4, $urandom_range(1), $urandom_range(255));
      sc_read();
    end
    f = $urandom_range(7);
    g = (f + 1) % 8;
    sc_write(0, f, 3, 0, 0);
    probe(8'h19, 1'b0, 8'hff, 8'h00);
    probe({3'h5, id ^ 4'h1, 1'b0}, 1'b0, 8'hff, 8'h00);
    probe({3'h2, id, 1'b1}, 1'b1, 8'hff, 8'h00);
    probe(8'h18, 1'b1, 8'hff, 8'h00);
    sc_read();
    abs_v[f] <= 1'b1;
    repeat (12) @(posedge clk);
    abs_v <= 8'h00;
    oflag[f] = 1;
    repeat (4) @(posedge clk);
    check(alert_n, 1'b0);
    check_fields();
    probe(8'h19, 1'b1, 8'hff, {3'h2, id, 1'b1});
    check(alert_n, 1'b1);
    probe(8'h19, 1'b0, 8'hff, 8'h00);
    sc_read();
    sc_write(0, f, 0, 0, 0);
    thr_v[g] <= 1'b1;
    repeat (P_CYC / 2) @(posedge clk);
    thr_v <= 8'h00;
    repeat (P_CYC) @(posedge clk);
    check(alert_n, 1'b1);
    check_fields();
    thr_v[g] <= 1'b1;
    repeat (2 * P_CYC) @(posedge clk);
    thr_v <= 8'h00;
    oflag[g] = 1;
    repeat (4) @(posedge clk);
    check(alert_n, 1'b0);
    check_fields();
    probe(8'h19, 1'b1, 8'hbf, 8'h3f);
    check(alert_n, 1'b0);
    probe(8'h19, 1'b1, 8'hff, {3'h2, id, 1'b1});
    sc_write(1, g, 2, 2, 0);
    sc_read();
    test_done();
  end
endmodule : led_bypass_i2c_command_fault_tb
bind lbicf_top lbicf_assertions #(.P_PERSIST_CYC(P_PERSIST_CYC)) i_lbicf_assertions (
  .i_clock, .i_nrst, .i_dim_clock, .i_scl, .i_sda, .i_open_abs, .i_open_thr, .o_sda,
  .o_sda_oe, .o_alert_n, .o_bypass_on, .o_open_trip_dv, .o_series_led_count);
